// *** rtl/hbp_ctrl.sv ***
`timescale 1ns/1ps
module hbp_ctrl #(
	parameter int UV_CYC = hbp_pkg::UV_CYC,
	parameter int SD_CYC = hbp_pkg::SD_CYC
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic serial_data_in_i,
	output logic serial_data_out_o,
	output logic serial_data_out_oe_o,
	input wire logic sleep_request_n_i,
	input wire logic supply_low_i,
	input wire logic [5:0] low_current_i,
	input wire logic [5:0] overcurrent_i,
	input wire logic prewarn_on_temp_i,
	input wire logic prewarn_off_temp_i,
	input wire logic shutdown_hot_i,
	input wire logic shutdown_cool_i,
	output logic [5:0] stage_on_o,
	output logic [5:0] stage_oe_o
);
	localparam int NS = hbp_pkg::N_STAGE;
	localparam int CNT_W_L = hbp_pkg::CNT_W;

	logic [hbp_pkg::PIN_W-1:0] pin_raw, pin_s1, pin_s2, pin_s3, pin;
	logic cs_n_s, sleep_ok, uv_lvl, pw_hi, pw_lo, ts_hot, ts_cool, done_tgl_s;
	logic done_tgl_q, cs_n_q, word_ready, exec, clr, overcurrent_shutdown_enable, rx_done_tgl_w;
	logic uv_acc, supply_fail_flag, ol_cond, ol_hit, open_load_flag, short_circuit_flag, tw, ts_lat, block_all;
	logic [5:0] ol_lvl, oc_lvl, oc_hit, oc_off, next_stage_on;
	logic [15:0] rx_word, cmd, status, status_hold;
	logic [CNT_W_L-1:0] uv_cnt, ol_cnt;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	assign pin_raw = {rx_done_tgl_w, shutdown_cool_i, shutdown_hot_i,
		prewarn_off_temp_i, prewarn_on_temp_i, overcurrent_i,
		low_current_i, supply_low_i, sleep_request_n_i, cs_n_i};

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pin_s1 <= hbp_pkg::PIN_RST;
			pin_s2 <= hbp_pkg::PIN_RST;
			pin_s3 <= hbp_pkg::PIN_RST;
			pin <= hbp_pkg::PIN_RST;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			// a bit moves only once stages two and three agree
			pin <= (~(pin_s2 ^ pin_s3) & pin_s2) | ((pin_s2 ^ pin_s3) & pin);
		end
	end

	assign cs_n_s = pin[0];
	assign sleep_ok = pin[1];
	assign uv_lvl = pin[2];
	assign ol_lvl = pin[8:3];
	assign oc_lvl = pin[14:9];
	assign pw_hi = pin[15];
	assign pw_lo = pin[16];
	assign ts_hot = pin[17];
	assign ts_cool = pin[18];
	assign done_tgl_s = pin[19];

	// ----------------------------------------------------------------
	// serial link
	// ----------------------------------------------------------------
	hbp_serial_link hbp_serial_link_inst (
		.sclk_i(sclk_i),
		.cs_n_i(cs_n_i),
		.srst_i(srst_i),
		.serial_data_in_i(serial_data_in_i),
		.status_word_i(status_hold),
		.serial_data_out_o(serial_data_out_o),
		.serial_data_out_oe_o(serial_data_out_oe_o),
		.rx_word_o(rx_word),
		.rx_done_tgl_o(rx_done_tgl_w)
	);

	// ----------------------------------------------------------------
	// word execution at select rise
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			done_tgl_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			done_tgl_q <= done_tgl_s;
			cs_n_q <= cs_n_s;
		end
	end

	// only full 16-bit frames raise the toggle
	always_ff @(posedge clk_i) begin
		if (srst_i || !sleep_ok) begin
			word_ready <= 1'b0;
		end else if (done_tgl_s != done_tgl_q) begin
			word_ready <= 1'b1;
		end else if (exec || (cs_n_q && !cs_n_s)) begin
			word_ready <= 1'b0;
		end
	end

	assign exec = word_ready && cs_n_s;

	always_ff @(posedge clk_i) begin
		if (srst_i || !sleep_ok) begin
			cmd <= hbp_pkg::CMD_RST;
		end else if (exec) begin
			cmd <= rx_word;
		end
	end

	// single pulse per executed word with the clear bit set
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			clr <= 1'b0;
		end else begin
			clr <= exec && rx_word[hbp_pkg::CMD_CLR];
		end
	end

	assign overcurrent_shutdown_enable = cmd[hbp_pkg::CMD_OCS];

	// ----------------------------------------------------------------
	// supply undervoltage
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i || !uv_lvl) begin
			uv_cnt <= '0;
			uv_acc <= 1'b0;
		end else if (uv_cnt != CNT_W_L'(UV_CYC)) begin
			uv_cnt <= uv_cnt + 1'b1;
		end else begin
			uv_acc <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || !sleep_ok) begin
			supply_fail_flag <= 1'b0;
		end else if (uv_acc) begin
			supply_fail_flag <= 1'b1;
		end else if (clr) begin
			supply_fail_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// open load
	// ----------------------------------------------------------------
	assign ol_cond = |(ol_lvl & stage_on_o);
	assign ol_hit = ol_cond && (ol_cnt == CNT_W_L'(SD_CYC));

	always_ff @(posedge clk_i) begin
		if (srst_i || !ol_cond || clr) begin
			ol_cnt <= '0;
		end else if (ol_cnt != CNT_W_L'(SD_CYC)) begin
			ol_cnt <= ol_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || !sleep_ok) begin
			open_load_flag <= 1'b0;
		end else if (ol_hit) begin
			open_load_flag <= 1'b1;
		end else if (clr) begin
			open_load_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// overcurrent, one filter per stage
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NS; i++) begin : g_oc
		logic [CNT_W_L-1:0] cnt;
		logic cond;

		assign cond = oc_lvl[i] && stage_on_o[i];
		assign oc_hit[i] = cond && (cnt == CNT_W_L'(SD_CYC));

		always_ff @(posedge clk_i) begin
			if (srst_i || !cond || clr) begin
				cnt <= '0;
			end else if (cnt != CNT_W_L'(SD_CYC)) begin
				cnt <= cnt + 1'b1;
			end
		end

		always_ff @(posedge clk_i) begin
			if (srst_i || !sleep_ok) begin
				oc_off[i] <= 1'b0;
			end else if (oc_hit[i] && overcurrent_shutdown_enable) begin
				oc_off[i] <= 1'b1;
			end else if (clr) begin
				oc_off[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || !sleep_ok) begin
			short_circuit_flag <= 1'b0;
		end else if (|oc_hit) begin
			short_circuit_flag <= 1'b1;
		end else if (clr) begin
			short_circuit_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// temperature
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i || !sleep_ok) begin
			tw <= 1'b0;
		end else if (pw_hi) begin
			tw <= 1'b1;
		end else if (pw_lo) begin
			tw <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || !sleep_ok) begin
			ts_lat <= 1'b0;
		end else if (ts_hot) begin
			ts_lat <= 1'b1;
		end else if (clr && ts_cool) begin
			ts_lat <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// output stages
	// ----------------------------------------------------------------
	assign block_all = uv_acc || ts_lat || !sleep_ok;
	assign next_stage_on = cmd[hbp_pkg::CMD_ON_LSB +: NS] & ~(oc_off & {NS{overcurrent_shutdown_enable}})
		& {NS{~block_all}};

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			stage_on_o <= 6'h00;
			stage_oe_o <= 6'h00;
		end else begin
			stage_on_o <= next_stage_on;
			stage_oe_o <= {NS{sleep_ok}};
		end
	end

	// ----------------------------------------------------------------
	// status word, frozen while a frame runs
	// ----------------------------------------------------------------
	always_comb begin
		status = hbp_pkg::ST_RST;
		status[hbp_pkg::ST_TW] = tw;
		status[hbp_pkg::ST_ON_LSB +: NS] = stage_on_o;
		status[hbp_pkg::ST_SCD] = short_circuit_flag;
		status[hbp_pkg::ST_OPL] = open_load_flag;
		status[hbp_pkg::ST_PSF] = supply_fail_flag;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			status_hold <= hbp_pkg::ST_RST;
		end else if (cs_n_s) begin
			status_hold <= status;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	a_inhibit_cmd_reset:
	assert property (!sleep_ok |=> cmd == hbp_pkg::CMD_RST)
		else $error("command word not at reset value during inhibit");
	a_uv_stages_off:
	assert property (uv_acc && sleep_ok |=> stage_on_o == 6'h00 && supply_fail_flag)
		else $error("undervoltage did not disable stages");
	a_uv_filter_time:
	assert property (uv_acc |-> $past(uv_lvl, 1) && uv_cnt == CNT_W_L'(UV_CYC))
		else $error("undervoltage accepted before filter time");
	a_uv_recover_now:
	assert property (!uv_lvl |=> !uv_acc)
		else $error("undervoltage not released at once");
	a_psf_sticky_flag:
	assert property (supply_fail_flag && !clr && sleep_ok |=> supply_fail_flag)
		else $error("supply fail dropped without clear");
	a_opl_set_cause:
	assert property ($rose(open_load_flag) |-> $past(ol_hit))
		else $error("open load set without filtered condition");
	a_tw_follow_temp:
	assert property (pw_hi && sleep_ok |=> tw)
		else $error("warning not set above set temperature");
	a_frame_abandon_keep:
	assert property (!word_ready && sleep_ok |=> $stable(cmd))
		else $error("command changed without full frame");
	a_tsd_stages_off:
	assert property (ts_lat |=> stage_on_o == 6'h00)
		else $error("stages on during thermal shutdown");
	a_tsd_release_cause:
	assert property ($fell(ts_lat) && $past(sleep_ok) |-> $past(clr && ts_cool))
		else $error("thermal shutdown released without clear and cooling");
	a_oc_disabled_keep:
	assert property (!overcurrent_shutdown_enable && !block_all |=> stage_on_o == $past(cmd[6:1]))
		else $error("stage changed by overcurrent with shutdown off");
	a_oc_shut_stage:
	assert property (|(oc_off & {NS{overcurrent_shutdown_enable}}) |=> (stage_on_o & $past(oc_off)) == 6'h00)
		else $error("shut stage still on");
	a_clear_flags_once:
	assert property (clr |=> !clr)
		else $error("clear held longer than one cycle");
	a_clear_drops_flags:
	assert property (clr && !uv_acc && !ol_hit && oc_hit == 6'h00
		|=> !supply_fail_flag && !open_load_flag && !short_circuit_flag && oc_off == 6'h00)
		else $error("clear word did not drop flags");
	a_inhibit_tristate:
	assert property (!sleep_ok |=> stage_oe_o == 6'h00 && !supply_fail_flag && !short_circuit_flag && !open_load_flag)
		else $error("inhibit did not tri-state and erase");

	c_word_exec: cover property (exec ##1 clr);
	c_uv_accept: cover property ($rose(uv_acc));
	c_oc_shutdown: cover property ($rose(oc_off[0]) && overcurrent_shutdown_enable);
	c_short_frame: cover property ($rose(cs_n_s) && !word_ready);
endmodule : hbp_ctrl

// *** rtl/hbp_pkg.sv ***
// ----------------------------------------------------------------
// half-bridge protection control constants
// ----------------------------------------------------------------
package hbp_pkg;
	// word geometry
	localparam int WORD_W = 16;
	localparam int N_STAGE = 6;
	localparam int CNT_W = 16;

	// command word fields
	localparam int CMD_CLR = 0;
	localparam int CMD_ON_LSB = 1;
	localparam int CMD_OCS = 13;
	localparam logic [15:0] CMD_RST = 16'h2000;

	// status word fields
	localparam int ST_TW = 0;
	localparam int ST_ON_LSB = 1;
	localparam int ST_SCD = 13;
	localparam int ST_OPL = 14;
	localparam int ST_PSF = 15;
	localparam logic [15:0] ST_RST = 16'h0000;

	// timing
	localparam int CLK_MHZ = 125;
	localparam int UV_FILTER_NS = 10000;
	localparam int SD_FILTER_NS = 10000;
	localparam int UV_CYC = (UV_FILTER_NS * CLK_MHZ + 999) / 1000;
	localparam int SD_CYC = (SD_FILTER_NS * CLK_MHZ + 999) / 1000;

	// pin synchroniser: cs_n idles high, everything else low
	localparam int PIN_W = 20;
	localparam logic [19:0] PIN_RST = 20'h00001;
endpackage : hbp_pkg

// *** rtl/hbp_serial_link.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// serial link end, runs on the link clock
// ----------------------------------------------------------------
module hbp_serial_link (
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic srst_i,
	input wire logic serial_data_in_i,
	input wire logic [15:0] status_word_i,
	output logic serial_data_out_o,
	output logic serial_data_out_oe_o,
	output logic [15:0] rx_word_o,
	output logic rx_done_tgl_o
);
	logic [4:0] rx_count;
	logic [4:0] tx_idx;
	logic [15:0] rx_shift;
	logic [15:0] next_shift;

	assign next_shift = {serial_data_in_i, rx_shift[15:1]};

	// ----------------------------------------------------------------
	// receive: sample on falling clock, lsb first
	// ----------------------------------------------------------------
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			rx_count <= 5'h00;
			rx_shift <= 16'h0000;
		end else begin
			rx_shift <= next_shift;
			if (rx_count != 5'h10) begin
				rx_count <= rx_count + 5'h01;
			end
		end
	end

	// completed word, handed over with a toggle
	always_ff @(negedge sclk_i or posedge srst_i) begin
		if (srst_i) begin
			rx_word_o <= 16'h0000;
			rx_done_tgl_o <= 1'b0;
		end else if (!cs_n_i && rx_count == 5'h0F) begin
			rx_word_o <= next_shift;
			rx_done_tgl_o <= ~rx_done_tgl_o;
		end
	end

	// ----------------------------------------------------------------
	// transmit: index advances on rising clock
	// ----------------------------------------------------------------
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			tx_idx <= 5'h00;
		end else begin
			tx_idx <= rx_count;
		end
	end

	// bit 0 is on the pin as soon as select falls
	assign serial_data_out_oe_o = ~cs_n_i;
	assign serial_data_out_o = tx_idx[4] ? 1'b0 : status_word_i[tx_idx[3:0]];
endmodule : hbp_serial_link

// *** bench/hbp_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// serial host: frames words, link clock still between frames
// ----------------------------------------------------------------
module hbp_host_model (
	output logic sclk_o,
	output logic cs_n_o,
	output logic serial_data_in_o,
	input wire logic serial_data_out_i,
	input wire logic serial_data_out_oe_i
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		serial_data_in_o = 1'b0;
	end

	// ----------------------------------------------------------------
	// one frame; fewer than 16 bits abandons it, gap_ns slows the start
	// ----------------------------------------------------------------
	task automatic frame(input logic [15:0] cmd, input int nbits, input int gap_ns,
			output logic [15:0] rd);
		rd = 16'h0000;
		#7;
		cs_n_o = 1'b0;
		serial_data_in_o = cmd[0];
		#(2 + gap_ns);
		for (int k = 0; k < nbits; k++) begin
			#13 sclk_o = 1'b1;
			#15 sclk_o = 1'b0;
			if (serial_data_out_oe_i) begin
				rd[k] = serial_data_out_i;
			end
			#2 serial_data_in_o = (k < 15) ? cmd[k + 1] : ~serial_data_in_o;
		end
		#13 cs_n_o = 1'b1;
		// released line shows no stale bit
		serial_data_in_o = ~serial_data_in_o;
	endtask : frame
endmodule : hbp_host_model

// *** bench/hbp_ctrl_bench.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// testbench for the half-bridge protection control
// ----------------------------------------------------------------
module hbp_ctrl_bench;
	logic clk_i, srst_i, sclk_i, cs_n_i, serial_data_in_i;
	logic serial_data_out_o, serial_data_out_oe_o;
	logic sleep_request_n_i, supply_low_i, prewarn_on_temp_i, prewarn_off_temp_i;
	logic shutdown_hot_i, shutdown_cool_i;
	logic [5:0] low_current_i, overcurrent_i, stage_on_o, stage_oe_o;
	logic [15:0] st;
	int mismatches, n_checks;

	hbp_ctrl #(.UV_CYC(8), .SD_CYC(8)) hbp_ctrl_inst (
		.clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
		.serial_data_in_i(serial_data_in_i), .serial_data_out_o(serial_data_out_o),
		.serial_data_out_oe_o(serial_data_out_oe_o), .sleep_request_n_i(sleep_request_n_i),
		.supply_low_i(supply_low_i), .low_current_i(low_current_i),
		.overcurrent_i(overcurrent_i), .prewarn_on_temp_i(prewarn_on_temp_i),
		.prewarn_off_temp_i(prewarn_off_temp_i), .shutdown_hot_i(shutdown_hot_i),
		.shutdown_cool_i(shutdown_cool_i), .stage_on_o(stage_on_o), .stage_oe_o(stage_oe_o)
	);

	hbp_host_model hbp_host_model_inst (
		.sclk_o(sclk_i), .cs_n_o(cs_n_i), .serial_data_in_o(serial_data_in_i),
		.serial_data_out_i(serial_data_out_o), .serial_data_out_oe_i(serial_data_out_oe_o)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wclk(input int n);
		repeat (n) @(negedge clk_i);
	endtask : wclk

	task automatic xfer(input logic [15:0] cmd, input int nbits, input int gap_ns);
		hbp_host_model_inst.frame(cmd, nbits, gap_ns, st);
		wclk(12);
	endtask : xfer

	task automatic stg(input logic [5:0] exp);
		chk("stage_on", {10'h000, exp}, {10'h000, stage_on_o});
	endtask : stg

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run

	// ----------------------------------------------------------------
	// clock, watchdog
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	initial begin
		#200000;
		mismatches++;
		complete_run();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		srst_i = 1'b1;
		sleep_request_n_i = 1'b1;
		supply_low_i = 1'b0;
		low_current_i = 6'h00;
		overcurrent_i = 6'h00;
		prewarn_on_temp_i = 1'b0;
		prewarn_off_temp_i = 1'b1;
		shutdown_hot_i = 1'b0;
		shutdown_cool_i = 1'b1;
		wclk(8);
		srst_i = 1'b0;
		wclk(8);
		stg(6'h00);
		chk("stage_oe", 16'h003F, {10'h000, stage_oe_o});
		chk("data_out_oe", 16'h0000, {15'h0000, serial_data_out_oe_o});
		xfer(16'h007E, 8, 0);
		stg(6'h00);
		xfer(16'h207E, 16, 100);
		stg(6'h3F);
		xfer(16'h207E, 16, 0);
		chk("status", 16'h007E, st);
		// warning read by one-bit frames
		prewarn_on_temp_i = 1'b1;
		prewarn_off_temp_i = 1'b0;
		wclk(10);
		xfer(16'h0000, 1, 0);
		chk("warn", 16'h0001, {15'h0000, st[0]});
		stg(6'h3F);
		prewarn_on_temp_i = 1'b0;
		prewarn_off_temp_i = 1'b1;
		wclk(10);
		xfer(16'h0000, 1, 0);
		chk("warn", 16'h0000, {15'h0000, st[0]});
		// overcurrent with shutdown enabled
		overcurrent_i = 6'h01;
		wclk(25);
		stg(6'h3E);
		overcurrent_i = 6'h00;
		xfer(16'h207E, 16, 0);
		chk("status", 16'h207C, st);
		xfer(16'h207F, 16, 0);
		stg(6'h3F);
		xfer(16'h207E, 16, 0);
		chk("status", 16'h007E, st);
		// overcurrent with shutdown disabled
		xfer(16'h007E, 16, 0);
		overcurrent_i = 6'h02;
		wclk(25);
		stg(6'h3F);
		overcurrent_i = 6'h00;
		xfer(16'h007E, 16, 0);
		chk("status", 16'h207E, st);
		// clear while the fault persists: the filter hit outweighs the clear pulse, so the flag stays set
		overcurrent_i = 6'h02;
		wclk(25);
		xfer(16'h007F, 16, 0);
		wclk(10);
		overcurrent_i = 6'h00;
		xfer(16'h007E, 16, 0);
		chk("status", 16'h207E, st);
		xfer(16'h207F, 16, 0);
		// undervoltage: short dip, then a long one
		supply_low_i = 1'b1;
		wclk(4);
		supply_low_i = 1'b0;
		wclk(10);
		stg(6'h3F);
		supply_low_i = 1'b1;
		wclk(25);
		stg(6'h00);
		supply_low_i = 1'b0;
		wclk(8);
		stg(6'h3F);
		xfer(16'h207E, 16, 0);
		chk("status", 16'h807E, st);
		xfer(16'h207F, 16, 0);
		xfer(16'h207E, 16, 0);
		chk("status", 16'h007E, st);
		// open load: short blip ignored, long one latched
		low_current_i = 6'h04;
		wclk(4);
		low_current_i = 6'h00;
		xfer(16'h207E, 16, 0);
		chk("status", 16'h007E, st);
		low_current_i = 6'h04;
		wclk(25);
		low_current_i = 6'h00;
		xfer(16'h207E, 16, 0);
		chk("status", 16'h407E, st);
		xfer(16'h207F, 16, 0);
		xfer(16'h207E, 16, 0);
		chk("status", 16'h007E, st);
		// thermal shutdown and release
		shutdown_hot_i = 1'b1;
		shutdown_cool_i = 1'b0;
		wclk(8);
		shutdown_hot_i = 1'b0;
		wclk(4);
		stg(6'h00);
		xfer(16'h207F, 16, 0);
		stg(6'h00);
		xfer(16'h207E, 16, 0);
		chk("status", 16'h0000, st);
		shutdown_cool_i = 1'b1;
		wclk(8);
		xfer(16'h207F, 16, 0);
		stg(6'h3F);
		// inhibit
		sleep_request_n_i = 1'b0;
		wclk(8);
		chk("stage_oe", 16'h0000, {10'h000, stage_oe_o});
		stg(6'h00);
		sleep_request_n_i = 1'b1;
		wclk(10);
		chk("stage_oe", 16'h003F, {10'h000, stage_oe_o});
		stg(6'h00);
		xfer(16'h2000, 16, 0);
		chk("status", 16'h0000, st);
		complete_run();
	end
endmodule : hbp_ctrl_bench
